// file: logic/tw_pkg.sv
// package: constants and carriers for the table write unit
package tw_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int CYCLE_NS = 1000000000 / CLK_HZ;
   // one instruction cycle is four clock phases
   localparam int PHASES_PER_CYCLE = 4;
   localparam logic [5:0] OPC_TABLE_WRITE = 6'h2b;
   localparam logic [5:0] OPC_TABLE_READ = 6'h2a;
   localparam int OPC_LSB = 10;
   localparam int HALF_SEL_BIT = 9;
   localparam int INCR_SEL_BIT = 8;
   localparam int SHORT_WRITE_CYCLES = 2;
   localparam logic [15:0] LATCH_RESET = 16'h0000;
   localparam logic [15:0] POINTER_RESET = 16'h0000;
   localparam logic [15:0] INTERNAL_TOP_DEFAULT = 16'h3fff;
   localparam int PROG_CYCLES_DEFAULT = 25000;
   // apb register byte addresses
   localparam logic [7:0] ADDR_INSTR = 8'h00;
   localparam logic [7:0] ADDR_LATCH = 8'h04;
   localparam logic [7:0] ADDR_POINTER = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_FILE = 8'h10;
   localparam logic [7:0] ADDR_LAST_ADDR = 8'h14;
   localparam logic [7:0] ADDR_LAST_DATA = 8'h18;
   localparam int ST_BUSY = 0;
   localparam int ST_ABORTED = 1;
   localparam int ST_CUT = 2;
   localparam int ST_DONE = 3;

   typedef enum logic [1:0] {
      TW_IDLE = 2'b00,
      TW_LOAD = 2'b01,
      TW_WRITE = 2'b11,
      TW_PROG = 2'b10
   } tw_state_type;

   typedef struct packed {
      logic strobe;
      logic [15:0] addr;
      logic [15:0] data;
      logic internal;
   } tw_mem_req_type;
endpackage : tw_pkg

// file: logic/tw_phase_div.sv
// instruction-cycle divider: one pulse per instruction cycle
`timescale 1ns/1ps
module tw_phase_div #(
   parameter int PHASES = tw_pkg::PHASES_PER_CYCLE
) (
   input wire logic pclk,
   input wire logic presetn,
   output logic cycle_tick
);
   initial begin
      if (PHASES < 1 || PHASES > 255) $error("phase count out of range");
   end
   logic [7:0] cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 8'h00;
         cycle_tick <= 1'b0;
      end else begin
         cycle_tick <= (cnt == 8'(PHASES - 1));
         cnt <= (cnt == 8'(PHASES - 1)) ? 8'h00 : cnt + 8'h01;
      end
   end
endmodule : tw_phase_div

// file: logic/tw_table_write.sv
// table write unit: latch, pointer, program memory write sequencing
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// How it works
// - table write copies file byte to latch high if half bit 1, else low.
// - after the latch update, whole latch written to word at table pointer.
// - increment bit 1 adds one to pointer after write; 0 leaves it.
// - writes to external memory finish within two instruction cycles.
// - normal write takes two cycles; internal eprom write lasts programming time.
// - interrupt during the programming phase ends an internal eprom write at once.
// - without programming voltage, internal programming aborts; short two-cycle write.
// - aborted internal write leaves the memory word unchanged.
// - latch is 16 bits, halves reachable separately, written as one word.
module tw_table_write #(
   parameter logic [15:0] INTERNAL_TOP = tw_pkg::INTERNAL_TOP_DEFAULT,
   parameter int PROG_CYCLES = tw_pkg::PROG_CYCLES_DEFAULT
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic irq_in,
   input wire logic prog_voltage_ok,
   output tw_pkg::tw_mem_req_type mem_req
);
   initial begin
      if (PROG_CYCLES < tw_pkg::SHORT_WRITE_CYCLES) $error("programming too short");
   end

   typedef struct packed {
      tw_pkg::tw_state_type state;
      logic [15:0] table_latch;
      logic [15:0] table_pointer;
      logic [7:0] file_reg;
      logic incr;
      logic [31:0] cnt;
      logic busy;
      logic aborted;
      logic cut;
      logic done;
      logic [15:0] last_addr;
      logic [15:0] last_data;
      tw_pkg::tw_mem_req_type req;
      logic [31:0] rdata;
      logic slverr;
      logic ready;
   } tw_regs_type;

   tw_regs_type r, next_r;
   logic tick;
   logic access;
   logic [15:0] instr;

   tw_phase_div #(.PHASES(tw_pkg::PHASES_PER_CYCLE)) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .cycle_tick(tick)
   );

   assign access = psel && penable && !r.ready;
   assign instr = pwdata[15:0];

   always_comb begin
      next_r = r;
      next_r.ready = 1'b0;
      next_r.req.strobe = 1'b0;
      // register slave: one wait state, answers on the second access edge
      if (access) begin
         next_r.ready = 1'b1;
         next_r.slverr = 1'b0;
         next_r.rdata = 32'h0;
         if (pwrite) begin
            case (paddr)
               tw_pkg::ADDR_INSTR: begin
                  // busy unit refuses a new instruction
                  if (r.busy || instr[15:10] != tw_pkg::OPC_TABLE_WRITE) begin
                     next_r.slverr = 1'b1;
                  end else begin
                     next_r.busy = 1'b1;
                     next_r.done = 1'b0;
                     next_r.aborted = 1'b0;
                     next_r.cut = 1'b0;
                     next_r.incr = instr[tw_pkg::INCR_SEL_BIT];
                     if (instr[tw_pkg::HALF_SEL_BIT]) begin
                        next_r.table_latch[15:8] = r.file_reg;
                     end else begin
                        next_r.table_latch[7:0] = r.file_reg;
                     end
                     next_r.state = tw_pkg::TW_LOAD;
                     next_r.cnt = 32'h0;
                  end
               end
               tw_pkg::ADDR_LATCH: begin
                  if (!r.busy) next_r.table_latch = pwdata[15:0];
               end
               tw_pkg::ADDR_POINTER: begin
                  if (!r.busy) next_r.table_pointer = pwdata[15:0];
               end
               tw_pkg::ADDR_FILE: next_r.file_reg = pwdata[7:0];
               tw_pkg::ADDR_STATUS: ;
               default: next_r.slverr = 1'b1;
            endcase
         end else begin
            case (paddr)
               tw_pkg::ADDR_LATCH: next_r.rdata = {16'h0, r.table_latch};
               tw_pkg::ADDR_POINTER: next_r.rdata = {16'h0, r.table_pointer};
               tw_pkg::ADDR_STATUS: next_r.rdata = {28'h0, r.done, r.cut, r.aborted, r.busy};
               tw_pkg::ADDR_FILE: next_r.rdata = {24'h0, r.file_reg};
               tw_pkg::ADDR_LAST_ADDR: next_r.rdata = {16'h0, r.last_addr};
               tw_pkg::ADDR_LAST_DATA: next_r.rdata = {16'h0, r.last_data};
               tw_pkg::ADDR_INSTR: ;
               default: next_r.slverr = 1'b1;
            endcase
         end
      end
      case (r.state)
         tw_pkg::TW_IDLE: ;
         tw_pkg::TW_LOAD: begin
            // first instruction cycle: latch half already loaded
            if (tick) next_r.state = tw_pkg::TW_WRITE;
         end
         tw_pkg::TW_WRITE: begin
            if (tick) begin
               next_r.req.addr = r.table_pointer;
               next_r.req.data = r.table_latch;
               next_r.req.internal = (r.table_pointer <= INTERNAL_TOP);
               if (r.table_pointer > INTERNAL_TOP || !prog_voltage_ok) begin
                  // external, or short write without voltage: no word touched inside
                  next_r.req.strobe = (r.table_pointer > INTERNAL_TOP);
                  next_r.aborted = (r.table_pointer <= INTERNAL_TOP);
                  next_r.state = tw_pkg::TW_IDLE;
                  next_r.busy = 1'b0;
                  next_r.done = 1'b1;
                  if (r.incr) next_r.table_pointer = r.table_pointer + 16'h1;
                  next_r.last_addr = r.table_pointer;
                  next_r.last_data = r.table_latch;
               end else begin
                  next_r.state = tw_pkg::TW_PROG;
                  next_r.cnt = 32'h0;
               end
            end
         end
         tw_pkg::TW_PROG: begin
            next_r.cnt = r.cnt + 32'h1;
            // interrupt or lost voltage ends programming; word then left as it was
            if (irq_in || !prog_voltage_ok || r.cnt >= 32'(PROG_CYCLES - 1)) begin
               next_r.cut = irq_in;
               next_r.aborted = !prog_voltage_ok;
               next_r.req.strobe = !irq_in && prog_voltage_ok;
               next_r.req.addr = r.table_pointer;
               next_r.req.data = r.table_latch;
               next_r.req.internal = 1'b1;
               next_r.state = tw_pkg::TW_IDLE;
               next_r.busy = 1'b0;
               next_r.done = 1'b1;
               if (r.incr) next_r.table_pointer = r.table_pointer + 16'h1;
               next_r.last_addr = r.table_pointer;
               next_r.last_data = r.table_latch;
            end
         end
         default: next_r.state = tw_pkg::TW_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{state: tw_pkg::TW_IDLE, table_latch: tw_pkg::LATCH_RESET,
                table_pointer: tw_pkg::POINTER_RESET, default: '0};
      end else begin
         r <= next_r;
      end
   end

   assign prdata = r.rdata;
   assign pready = r.ready;
   assign pslverr = r.slverr;
   assign mem_req = r.req;

   a_ext_write_short: assert property (@(posedge pclk) disable iff (!presetn)
      (r.state == tw_pkg::TW_LOAD && tick) |-> ##[1:5] (r.state != tw_pkg::TW_WRITE))
      else $error("write phase overran");
   a_ext_strobe_data: assert property (@(posedge pclk) disable iff (!presetn)
      (r.state == tw_pkg::TW_WRITE && tick && r.table_pointer > INTERNAL_TOP) |=>
      (mem_req.strobe && mem_req.data == $past(r.table_latch)
       && mem_req.addr == $past(r.table_pointer)))
      else $error("external write wrong");
   a_ptr_incr: assert property (@(posedge pclk) disable iff (!presetn)
      (r.busy && !next_r.busy && r.incr) |=> (r.table_pointer == $past(r.table_pointer) + 16'h1))
      else $error("pointer not incremented");
   a_ptr_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (r.busy && !next_r.busy && !r.incr) |=> $stable(r.table_pointer))
      else $error("pointer moved");
   a_irq_cuts: assert property (@(posedge pclk) disable iff (!presetn)
      (r.state == tw_pkg::TW_PROG && irq_in) |=> (r.state == tw_pkg::TW_IDLE && r.cut))
      else $error("interrupt did not end write");
   a_novpp_nowrite: assert property (@(posedge pclk) disable iff (!presetn)
      (r.state == tw_pkg::TW_WRITE && tick && !prog_voltage_ok
       && r.table_pointer <= INTERNAL_TOP) |=> (!mem_req.strobe && r.aborted && !r.busy))
      else $error("unpowered write not aborted");
   a_cut_no_strobe: assert property (@(posedge pclk) disable iff (!presetn)
      (mem_req.strobe && mem_req.internal) |-> (!r.cut && !r.aborted))
      else $error("aborted write strobed");
   a_latch_high: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && paddr == tw_pkg::ADDR_INSTR && !r.busy
       && pwdata[15:10] == tw_pkg::OPC_TABLE_WRITE && pwdata[9])
      |=> (r.table_latch[15:8] == $past(r.file_reg) && $stable(r.table_latch[7:0])))
      else $error("high half not loaded");
   a_latch_low: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && paddr == tw_pkg::ADDR_INSTR && !r.busy
       && pwdata[15:10] == tw_pkg::OPC_TABLE_WRITE && !pwdata[9])
      |=> (r.table_latch[7:0] == $past(r.file_reg) && $stable(r.table_latch[15:8])))
      else $error("low half not loaded");
   c_ext_write: cover property (@(posedge pclk) mem_req.strobe && !mem_req.internal);
   c_int_write: cover property (@(posedge pclk) mem_req.strobe && mem_req.internal);
   c_irq_cut: cover property (@(posedge pclk) r.cut && r.done);
   c_abort: cover property (@(posedge pclk) r.aborted && r.done);
endmodule : tw_table_write

// file: dv/tw_prog_mem.sv
// far-side program memory model: keeps every word strobed by the unit
`timescale 1ns/1ps
module tw_prog_mem (
   input wire logic pclk,
   input wire tw_pkg::tw_mem_req_type mem_req
);
   // sparse store, so an untouched word simply does not exist
   logic [15:0] mem [logic [15:0]];
   always @(posedge pclk) begin
      if (mem_req.strobe === 1'b1) begin
         mem[mem_req.addr] = mem_req.data;
      end
   end
endmodule : tw_prog_mem

// file: dv/tw_table_write_tb.sv
// testbench for the table write unit
`timescale 1ns/1ps
module tw_table_write_tb;
   typedef struct packed {logic in; logic [15:0] a; logic [15:0] d;} tw_note_type;
   localparam int PROG = 20;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, irq_in = 0, prog_voltage_ok = 1, e;
   tw_pkg::tw_mem_req_type mem_req;
   tw_note_type q[$], nt;
   int n_errors = 0, n_compared = 0, cyc = 0, seed = 32'h2b88;
   logic [15:0] lat = 16'h0000;
   realtime t0;
   tw_table_write #(.PROG_CYCLES(PROG)) u_tw_table_write (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_in(irq_in),
      .prog_voltage_ok(prog_voltage_ok), .mem_req(mem_req));
   tw_prog_mem u_tw_prog_mem (.pclk(pclk), .mem_req(mem_req));
   initial begin
      forever #20 pclk = ~pclk;
   end
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task test_done;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 20000) begin
         n_errors++;
         test_done();
      end
   end
   // monitor: every strobed word must match the oldest note
   always @(posedge pclk) begin
      if (mem_req.strobe === 1'b1) begin
         if (q.size() == 0) check("unexpected write", 1, 0);
         else begin
            nt = q.pop_front();
            check("mem addr", mem_req.addr, nt.a);
            check("mem data", mem_req.data, nt.d);
            check("mem internal", mem_req.internal, nt.in);
            if (nt.in) check("prog time", ($realtime - t0) >= PROG * 40, 1);
            else check("ext time", ($realtime - t0) <= 10 * 40, 1);
         end
      end
   end
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // no local limit: only the bench timeout ends a hung access
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask : apb
   task op(input logic t, i, input logic [15:0] ptr, input logic vok, irq,
      input logic [3:0] st);
      logic [7:0] f;
      logic [15:0] w;
      int n;
      f = 8'($random(seed));
      w = t ? {f, lat[7:0]} : {lat[15:8], f};
      apb(1, tw_pkg::ADDR_POINTER, {16'h0, ptr});
      apb(1, tw_pkg::ADDR_FILE, {24'h0, f});
      prog_voltage_ok <= vok;
      // only a clean completion strobes a word
      if (st[3:1] == 3'b100) q.push_back({ptr <= tw_pkg::INTERNAL_TOP_DEFAULT, ptr, w});
      apb(1, tw_pkg::ADDR_INSTR, {16'h0, tw_pkg::OPC_TABLE_WRITE, t, i, 8'h07});
      t0 = $realtime;
      lat = w;
      if (irq) repeat (9) @(posedge pclk);
      irq_in <= irq;
      n = 0;
      do apb(0, tw_pkg::ADDR_STATUS, 0); while (r[0] !== 1'b0 && ++n < 100);
      irq_in <= 0;
      check("status", r, {28'h0, st});
      if (st[1]) check("short write", ($realtime - t0) < PROG * 40, 1);
      apb(0, tw_pkg::ADDR_POINTER, 0);
      check("pointer", r, {16'h0, ptr} + i);
      apb(0, tw_pkg::ADDR_LATCH, 0);
      check("latch", r, {16'h0, w});
   endtask : op
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      for (int k = 1; k < 4; k++) begin
         apb(0, 8'(4 * k), 0);
         check("reset value", r, 0);
      end
      op(1, 1, 16'ha356, 1, 0, 4'h8);
      op(0, 0, 16'h4000, 1, 0, 4'h8);
      op(1, 0, 16'h3fff, 1, 0, 4'h8);
      apb(0, tw_pkg::ADDR_LAST_ADDR, 0);
      check("last addr", r, 32'h0000_3fff);
      apb(0, tw_pkg::ADDR_LAST_DATA, 0);
      check("last data", r, {16'h0, lat});
      apb(0, tw_pkg::ADDR_INSTR, 0);
      check("instr read", r, 0);
      // interrupt lands in the programming phase, so no word is written
      // done is set on every completion, cut or aborted on top of it
      op(0, 1, 16'h0100, 1, 1, 4'hc);
      check("cut word untouched", u_tw_prog_mem.mem.exists(16'h0100), 0);
      op(1, 1, 16'h0200, 0, 0, 4'ha);
      check("word untouched", u_tw_prog_mem.mem.exists(16'h0200), 0);
      apb(1, tw_pkg::ADDR_INSTR, {16'h0, tw_pkg::OPC_TABLE_READ, 10'h0});
      check("bad opcode", e, 1);
      apb(0, 8'h1c, 0);
      check("unmapped", e, 1);
      check("notes left", q.size(), 0);
      test_done();
   end
endmodule : tw_table_write_tb
